// file: fault_mem.sv
`timescale 1ns/100ps
module fault_mem #(
  parameter int DATA_W = 8,
  parameter int DEPTH = 48,
  parameter int ADDR_W = 6
) (
  input wire logic clk_in,
  input wire logic en_in,
  input wire logic wr_en_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  output logic [DATA_W-1:0] rd_data_out
);

  logic [DATA_W-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // Storage, no reset: contents are written by the detection engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (en_in) begin
      if (wr_en_in) begin
        mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule : fault_mem

// file: host_port_monitor.sv
`timescale 1ns/100ps
module host_port_monitor
  import led_i2c_pkg::*;
#(
  parameter int AUTO_CLEAR_LIMIT = 50
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic link_clk_in,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic irq_n_out,
  input wire logic [BYTE_W-1:0] page_out,
  input wire logic page_wr_en_out,
  input wire logic [BYTE_W-1:0] page_wr_page_out,
  input wire logic [BYTE_W-1:0] page_wr_addr_out,
  input wire logic [BYTE_W-1:0] page_wr_data_out
);
  // ------------------------------------------------
  // Link side
  // ------------------------------------------------
  open_drain_a:
    assert property (@(posedge link_clk_in) disable iff (rst_in) sda_out == 1'b0)
    else $error("sda driven high");
  oe_rise_a:
    assert property (@(posedge link_clk_in) disable iff (rst_in) $rose(sda_oe_out) |-> !scl_in)
    else $error("sda pulled while scl high");
  oe_fall_a:
    assert property (@(posedge link_clk_in) disable iff (rst_in) $fell(sda_oe_out) |-> !scl_in)
    else $error("sda released while scl high");
  ack_hold_a:
    assert property (@(posedge link_clk_in) disable iff (rst_in) $rose(sda_oe_out) |=> sda_oe_out [*3])
    else $error("low slot too short");
  // ------------------------------------------------
  // System side, and cover points for both sides
  // ------------------------------------------------
  reset_values_a:
    assert property (@(posedge sys_clk_in) disable iff (rst_in)
      $fell(rst_in) |-> page_out == PAGE_RESET && irq_n_out && !page_wr_en_out)
    else $error("outputs not at reset values");
  page_legal_a:
    assert property (@(posedge sys_clk_in) disable iff (rst_in) page_out <= FUNCTION_PAGE)
    else $error("reserved page selected");
  wr_pulse_a:
    assert property (@(posedge sys_clk_in) disable iff (rst_in) page_wr_en_out |=> !page_wr_en_out [*8])
    else $error("write strobe too long");
  wr_addr_a:
    assert property (@(posedge sys_clk_in) disable iff (rst_in) page_wr_en_out |-> page_wr_addr_out < REG_IRQ_MASK)
    else $error("paged write to device register");
  wr_page_a:
    assert property (@(posedge sys_clk_in) disable iff (rst_in) page_wr_en_out |-> page_wr_page_out == page_out)
    else $error("paged write to wrong page");
  wr_hold_a:
    assert property (@(posedge sys_clk_in) disable iff (rst_in)
      !page_wr_en_out |-> $stable(page_wr_data_out) && $stable(page_wr_addr_out))
    else $error("write data not held");
  ack_seen_c: cover property (@(posedge link_clk_in) disable iff (rst_in) $rose(sda_oe_out));
  page_write_c: cover property (@(posedge sys_clk_in) disable iff (rst_in) page_wr_en_out);
  irq_low_c: cover property (@(posedge sys_clk_in) disable iff (rst_in) $fell(irq_n_out));
  irq_release_c: cover property (@(posedge sys_clk_in) disable iff (rst_in) $rose(irq_n_out));
endmodule : host_port_monitor

// file: i2c_master_model.sv
`timescale 1ns/100ps
module i2c_master_model #(
  parameter int HALF_NS = 440
) (
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Data moves mid-low so the target sees it settled
  task automatic clock_bit(input logic b, output logic seen);
    #(HALF_NS / 2);
    sda_low_out = !b;
    #(HALF_NS / 2);
    scl_out = 1'b1;
    #(HALF_NS / 2);
    seen = sda_in;
    #(HALF_NS / 2);
    scl_out = 1'b0;
  endtask : clock_bit
  // Also serves as repeated start
  task automatic start;
    #(HALF_NS / 2);
    sda_low_out = 1'b0;
    #(HALF_NS / 2);
    scl_out = 1'b1;
    #HALF_NS;
    sda_low_out = 1'b1;
    #HALF_NS;
    scl_out = 1'b0;
  endtask : start
  task automatic stop;
    #(HALF_NS / 2);
    sda_low_out = 1'b1;
    #(HALF_NS / 2);
    scl_out = 1'b1;
    #HALF_NS;
    sda_low_out = 1'b0;
    #HALF_NS;
  endtask : stop
  task automatic byte_io(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
    for (int i = 7; i >= 0; i--) begin
      clock_bit(tx[i], rx[i]);
    end
    clock_bit(ack_tx, ack_rx);
  endtask : byte_io
endmodule : i2c_master_model

// file: led_i2c_pkg.sv
package led_i2c_pkg;

  // ----------------------------------------------------------------
  // Target address and bus geometry
  // ----------------------------------------------------------------
  localparam logic [2:0] TARGET_ADDR_TOP = 3'h5;
  localparam int BYTE_W = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_STEP = 4'h1;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_IRQ_MASK = 8'hF0;
  localparam logic [7:0] REG_IRQ_FLAGS = 8'hF1;
  localparam logic [7:0] REG_PAGE_SELECT = 8'hFD;
  localparam logic [7:0] REG_UNLOCK_KEY = 8'hFE;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // ----------------------------------------------------------------
  // Values and field layouts
  // ----------------------------------------------------------------
  localparam logic [7:0] UNLOCK_VALUE = 8'hC5;
  localparam logic [7:0] LOCKED_VALUE = 8'h00;
  localparam logic [7:0] LED_CTRL_PAGE = 8'h00;
  localparam logic [7:0] PWM_PAGE = 8'h01;
  localparam logic [7:0] BREATH_MODE_PAGE = 8'h02;
  localparam logic [7:0] FUNCTION_PAGE = 8'h03;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] MASK_WRITABLE = 8'h0B;
  localparam int MASK_AUTO_CLEAR_BIT = 3;
  localparam int MASK_SHORT_BIT = 1;
  localparam int MASK_OPEN_BIT = 0;
  localparam int FLAG_BREATH3_BIT = 4;
  localparam int FLAG_BREATH2_BIT = 3;
  localparam int FLAG_BREATH1_BIT = 2;
  localparam int FLAG_SHORT_BIT = 1;
  localparam int FLAG_OPEN_BIT = 0;

  // ----------------------------------------------------------------
  // Fault map on the LED control page
  // ----------------------------------------------------------------
  localparam logic [7:0] FAULT_BASE = 8'h18;
  localparam logic [7:0] FAULT_READ_LAST = 8'h45;
  localparam logic [7:0] FUNC_RESET_REG = 8'h11;
  localparam int FAULT_DEPTH = 48;
  localparam int FAULT_ADDR_W = 6;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 250;
  localparam int AUTO_CLEAR_MS = 8;
  localparam int AUTO_CLEAR_CYCLES = AUTO_CLEAR_MS * 1000 * SYS_CLK_MHZ;
  localparam int AUTO_CLEAR_W = 32;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_REG = 4'h3,
    ST_REG_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RDATA_ACK = 4'h8
  } link_state_t;

endpackage : led_i2c_pkg

// file: led_matrix_i2c_host_port.sv
`timescale 1ns/100ps
module led_matrix_i2c_host_port
  import led_i2c_pkg::*;
#(
  parameter int AUTO_CLEAR_LIMIT = AUTO_CLEAR_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic link_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [1:0] addr_low_strap_in,
  input wire logic [1:0] addr_high_strap_in,
  input wire logic breath1_done_in,
  input wire logic breath2_done_in,
  input wire logic breath3_done_in,
  input wire logic short_fault_in,
  input wire logic open_fault_in,
  input wire logic fault_wr_en_in,
  input wire logic [FAULT_ADDR_W-1:0] fault_wr_addr_in,
  input wire logic [BYTE_W-1:0] fault_wr_data_in,
  output logic irq_n_out,
  output logic [BYTE_W-1:0] page_out,
  output logic page_wr_en_out,
  output logic [BYTE_W-1:0] page_wr_page_out,
  output logic [BYTE_W-1:0] page_wr_addr_out,
  output logic [BYTE_W-1:0] page_wr_data_out
);

  // ----------------------------------------------------------------
  // Link domain: pin synchronisers
  // ----------------------------------------------------------------
  localparam int PIN_W = 6;
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic scl_prev;
  logic sda_prev;
  wire [PIN_W-1:0] pin_raw = {addr_high_strap_in, addr_low_strap_in, sda_in, scl_in};
  wire scl_now = pin_sync[0];
  wire sda_now = pin_sync[1];
  wire [1:0] low_strap = pin_sync[3:2];
  wire [1:0] high_strap = pin_sync[5:4];

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_meta <= '1;
      pin_sync <= '1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      scl_prev <= scl_now;
      sda_prev <= sda_now;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: bus conditions and address match
  // ----------------------------------------------------------------
  wire scl_rise = scl_now & ~scl_prev;
  wire scl_fall = ~scl_now & scl_prev;
  wire start_seen = scl_now & scl_prev & sda_prev & ~sda_now;
  wire stop_seen = scl_now & scl_prev & ~sda_prev & sda_now;
  wire [6:0] own_addr = {TARGET_ADDR_TOP, high_strap, low_strap};

  link_state_t state;
  logic [3:0] bit_cnt;
  logic [BYTE_W-1:0] shift;
  logic [BYTE_W-1:0] ptr;
  logic read_dir;
  logic master_nack;
  logic sda_oe;
  logic req_tgl;
  logic req_is_write;
  logic [BYTE_W-1:0] req_addr;
  logic [BYTE_W-1:0] req_data;
  logic resp_meta;
  logic resp_sync;
  logic resp_prev;
  logic [BYTE_W-1:0] rd_hold;
  logic resp_tgl;
  logic [BYTE_W-1:0] rd_word;

  wire byte_done = bit_cnt == BITS_PER_BYTE;
  wire addr_match = shift[BYTE_W-1:1] == own_addr;
  wire resp_seen = resp_sync ^ resp_prev;

  assign sda_out = 1'b0;
  assign sda_oe_out = sda_oe;

  // ----------------------------------------------------------------
  // Link domain: read answer crossing
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      resp_meta <= 1'b0;
      resp_sync <= 1'b0;
      resp_prev <= 1'b0;
      rd_hold <= READ_ZERO;
    end else begin
      resp_meta <= resp_tgl;
      resp_sync <= resp_meta;
      resp_prev <= resp_sync;
      if (resp_seen) begin
        rd_hold <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Link domain: transfer sequencer
  // ----------------------------------------------------------------
  // Answers must arrive within one acknowledge slot; the link never stretches SCL.
  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      bit_cnt <= BIT_ZERO;
      shift <= READ_ZERO;
      ptr <= READ_ZERO;
      read_dir <= 1'b0;
      master_nack <= 1'b0;
      sda_oe <= 1'b0;
      req_tgl <= 1'b0;
      req_is_write <= 1'b0;
      req_addr <= READ_ZERO;
      req_data <= READ_ZERO;
    end else if (start_seen) begin
      state <= ST_ADDR;
      bit_cnt <= BIT_ZERO;
      sda_oe <= 1'b0;
    end else if (stop_seen) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        ST_ADDR, ST_REG, ST_WDATA: begin
          if (scl_rise && !byte_done) begin
            shift <= {shift[BYTE_W-2:0], sda_now};
            bit_cnt <= bit_cnt + BIT_STEP;
          end else if (scl_fall && byte_done) begin
            bit_cnt <= BIT_ZERO;
            if (state == ST_ADDR) begin
              if (addr_match) begin
                state <= ST_ADDR_ACK;
                sda_oe <= 1'b1;
                read_dir <= shift[0];
                if (shift[0]) begin
                  req_is_write <= 1'b0;
                  req_addr <= ptr;
                  req_tgl <= ~req_tgl;
                end
              end else begin
                state <= ST_IDLE;
              end
            end else if (state == ST_REG) begin
              state <= ST_REG_ACK;
              sda_oe <= 1'b1;
              ptr <= shift;
            end else begin
              state <= ST_WDATA_ACK;
              sda_oe <= 1'b1;
              req_is_write <= 1'b1;
              req_addr <= ptr;
              req_data <= shift;
              req_tgl <= ~req_tgl;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt <= BIT_ZERO;
            if (read_dir) begin
              state <= ST_RDATA;
              shift <= rd_hold;
              sda_oe <= ~rd_hold[BYTE_W-1];
            end else begin
              state <= ST_REG;
              sda_oe <= 1'b0;
            end
          end
        end
        ST_REG_ACK: begin
          if (scl_fall) begin
            state <= ST_WDATA;
            sda_oe <= 1'b0;
          end
        end
        ST_WDATA_ACK: begin
          if (scl_fall) begin
            state <= ST_WDATA;
            sda_oe <= 1'b0;
            ptr <= ptr + PTR_STEP;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == LAST_BIT) begin
              state <= ST_RDATA_ACK;
              sda_oe <= 1'b0;
              ptr <= ptr + PTR_STEP;
              req_is_write <= 1'b0;
              req_addr <= ptr + PTR_STEP;
              req_tgl <= ~req_tgl;
            end else begin
              shift <= {shift[BYTE_W-2:0], 1'b0};
              sda_oe <= ~shift[BYTE_W-2];
              bit_cnt <= bit_cnt + BIT_STEP;
            end
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            master_nack <= sda_now;
          end else if (scl_fall) begin
            bit_cnt <= BIT_ZERO;
            if (master_nack) begin
              state <= ST_IDLE;
            end else begin
              state <= ST_RDATA;
              shift <= rd_hold;
              sda_oe <= ~rd_hold[BYTE_W-1];
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // System domain: request crossing
  // ----------------------------------------------------------------
  logic req_meta;
  logic req_sync;
  logic req_prev;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_prev <= 1'b0;
    end else if (clk_en_in) begin
      req_meta <= req_tgl;
      req_sync <= req_meta;
      req_prev <= req_sync;
    end
  end

  // ----------------------------------------------------------------
  // System domain: decode
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] page_select;
  logic [BYTE_W-1:0] page_select_unlock_key;
  logic [BYTE_W-1:0] interrupt_enable_mask;
  logic [BYTE_W-1:0] interrupt_flags;
  logic [AUTO_CLEAR_W-1:0] low_cnt;
  logic [BYTE_W-1:0] fault_rd_data;

  // Request words are held steady by the link long before the toggle lands.
  wire req_seen = clk_en_in & (req_sync ^ req_prev);
  wire wr_hit = req_seen & req_is_write;
  wire rd_hit = req_seen & ~req_is_write;
  wire wr_mask = wr_hit && (req_addr == REG_IRQ_MASK);
  wire wr_page = wr_hit && (req_addr == REG_PAGE_SELECT);
  wire wr_key = wr_hit && (req_addr == REG_UNLOCK_KEY);
  wire wr_paged = wr_hit && (req_addr < REG_IRQ_MASK);
  wire unlocked = page_select_unlock_key == UNLOCK_VALUE;
  wire page_valid = req_data <= FUNCTION_PAGE;
  wire rd_flags = rd_hit && (req_addr == REG_IRQ_FLAGS);
  wire in_fault = (page_select == LED_CTRL_PAGE) && (req_addr >= FAULT_BASE) && (req_addr <= FAULT_READ_LAST);
  wire [BYTE_W-1:0] fault_offset = req_addr - FAULT_BASE;
  wire [BYTE_W-1:0] rd_value =
    (req_addr == REG_UNLOCK_KEY) ? page_select_unlock_key :
    (req_addr == REG_IRQ_FLAGS) ? interrupt_flags :
    in_fault ? fault_rd_data : READ_ZERO;

  wire [BYTE_W-1:0] flag_set = {3'h0, breath3_done_in, breath2_done_in, breath1_done_in,
                                short_fault_in, open_fault_in};
  wire irq_active = (interrupt_flags[FLAG_SHORT_BIT] & interrupt_enable_mask[MASK_SHORT_BIT]) |
                    (interrupt_flags[FLAG_OPEN_BIT] & interrupt_enable_mask[MASK_OPEN_BIT]);
  wire auto_clear_en = interrupt_enable_mask[MASK_AUTO_CLEAR_BIT];
  wire auto_clear = auto_clear_en && irq_active && (low_cnt == AUTO_CLEAR_W'(AUTO_CLEAR_LIMIT));
  wire flag_clear = rd_flags | auto_clear;
  wire [BYTE_W-1:0] next_flags = (interrupt_flags & ~({BYTE_W{flag_clear}})) | flag_set;

  assign irq_n_out = ~irq_active;
  assign page_out = page_select;

  fault_mem #(
    .DATA_W(BYTE_W),
    .DEPTH(FAULT_DEPTH),
    .ADDR_W(FAULT_ADDR_W)
  ) u_fault_mem (
    .clk_in(sys_clk_in),
    .en_in(clk_en_in),
    .wr_en_in(fault_wr_en_in),
    .wr_addr_in(fault_wr_addr_in),
    .wr_data_in(fault_wr_data_in),
    .rd_addr_in(fault_offset[FAULT_ADDR_W-1:0]),
    .rd_data_out(fault_rd_data)
  );

  // ----------------------------------------------------------------
  // System domain: command registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      page_select <= PAGE_RESET;
      page_select_unlock_key <= LOCKED_VALUE;
      interrupt_enable_mask <= MASK_RESET;
    end else if (clk_en_in) begin
      if (wr_page && unlocked && page_valid) begin
        page_select <= req_data;
      end
      if (wr_page && unlocked) begin
        page_select_unlock_key <= LOCKED_VALUE;
      end else if (wr_key) begin
        page_select_unlock_key <= req_data;
      end
      if (wr_mask) begin
        interrupt_enable_mask <= req_data & MASK_WRITABLE;
      end
    end
  end

  // ----------------------------------------------------------------
  // System domain: flags, auto clear and read answers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      interrupt_flags <= FLAGS_RESET;
      low_cnt <= '0;
      rd_word <= READ_ZERO;
      resp_tgl <= 1'b0;
    end else if (clk_en_in) begin
      interrupt_flags <= next_flags;
      if (!irq_active || !auto_clear_en || auto_clear) begin
        low_cnt <= '0;
      end else begin
        low_cnt <= low_cnt + 1'b1;
      end
      if (rd_hit) begin
        rd_word <= rd_value;
        resp_tgl <= ~resp_tgl;
      end
    end
  end

  // ----------------------------------------------------------------
  // System domain: paged write port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      page_wr_en_out <= 1'b0;
      page_wr_page_out <= PAGE_RESET;
      page_wr_addr_out <= READ_ZERO;
      page_wr_data_out <= READ_ZERO;
    end else if (clk_en_in) begin
      page_wr_en_out <= wr_paged;
      if (wr_paged) begin
        page_wr_page_out <= page_select;
        page_wr_addr_out <= req_addr;
        page_wr_data_out <= req_data;
      end
    end
  end

endmodule : led_matrix_i2c_host_port

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
  import led_i2c_pkg::*;
  localparam int LIMIT = 50;
  localparam logic [6:0] OWN_ADDR = {TARGET_ADDR_TOP, 2'h1, 2'h2};
  logic sys_clk_in = 1'b0;
  logic link_clk = 1'b0;
  logic rst_in = 1'b1;
  logic scl, m_low, sda_o, sda_oe, irq_n, wr_en;
  logic f_wr = 1'b0;
  logic [4:0] ev = 5'h00;
  logic [5:0] f_addr = 6'h00;
  logic [7:0] f_data = 8'h00;
  logic [7:0] page, wr_page, wr_addr, wr_data, rd;
  logic [23:0] seen_wr[$];
  int n_errors = 0;
  int comparisons = 0;
  wire sda = !(m_low || sda_oe);
  always #2 sys_clk_in = !sys_clk_in;
  initial begin
    #13;
    forever #40 link_clk = !link_clk;
  end
  led_matrix_i2c_host_port #(.AUTO_CLEAR_LIMIT(LIMIT)) u_dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(1'b1), .link_clk_in(link_clk),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .addr_low_strap_in(2'h2), .addr_high_strap_in(2'h1),
    .breath1_done_in(ev[2]), .breath2_done_in(ev[3]), .breath3_done_in(ev[4]),
    .short_fault_in(ev[1]), .open_fault_in(ev[0]),
    .fault_wr_en_in(f_wr), .fault_wr_addr_in(f_addr), .fault_wr_data_in(f_data),
    .irq_n_out(irq_n), .page_out(page), .page_wr_en_out(wr_en), .page_wr_page_out(wr_page),
    .page_wr_addr_out(wr_addr), .page_wr_data_out(wr_data));
  i2c_master_model #(.HALF_NS(320)) u_master (.sda_in(sda), .scl_out(scl), .sda_low_out(m_low));
  always @(posedge sys_clk_in) begin
    if (wr_en === 1'b1) begin
      seen_wr.push_back({wr_page, wr_addr, wr_data});
    end
  end
  // ------------------------------------------------
  // Compare, bus and event tasks
  // ------------------------------------------------
  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit
  task automatic check_val(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val
  task automatic send(input logic [7:0] b, input logic ack_exp, input string what);
    logic [7:0] rx;
    logic ack;
    u_master.byte_io(b, 1'b1, rx, ack);
    check_bit(what, ack_exp, ack);
  endtask : send
  task automatic head(input logic [7:0] ra);
    u_master.start();
    send({OWN_ADDR, 1'b0}, 1'b0, "address ack");
    send(ra, 1'b0, "register ack");
  endtask : head
  task automatic reg_write(input logic [7:0] ra, input logic [7:0] data[$]);
    head(ra);
    foreach (data[i]) send(data[i], 1'b0, "data ack");
    u_master.stop();
    repeat (20) @(negedge sys_clk_in);
  endtask : reg_write
  task automatic reg_read(input logic [7:0] ra, output logic [7:0] d);
    logic ack;
    head(ra);
    u_master.start();
    send({OWN_ADDR, 1'b1}, 1'b0, "read address ack");
    u_master.byte_io(8'hFF, 1'b1, d, ack);
    u_master.stop();
    repeat (20) @(negedge sys_clk_in);
  endtask : reg_read
  task automatic pulse(input logic [4:0] e);
    @(negedge sys_clk_in);
    ev = e;
    @(negedge sys_clk_in);
    ev = 5'h00;
    repeat (5) @(negedge sys_clk_in);
  endtask : pulse
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Tests need about 290 us of bus time
  initial begin
    #340000;
    n_errors++;
    tally_and_finish();
  end
  // ------------------------------------------------
  // Tests
  // ------------------------------------------------
  initial begin
    // Reset is asynchronous; the idle wait below fills the synchronisers
    repeat (16) @(negedge sys_clk_in);
    rst_in = 1'b0;
    repeat (300) @(negedge sys_clk_in);
    check_val("reset page", PAGE_RESET, page);
    check_bit("reset irq", 1'b1, irq_n);
    u_master.start();
    send({OWN_ADDR ^ 7'h02, 1'b0}, 1'b1, "foreign address nack");
    u_master.stop();
    $display("test address done");
    reg_write(REG_PAGE_SELECT, '{PWM_PAGE, UNLOCK_VALUE});
    check_val("locked page", LED_CTRL_PAGE, page);
    reg_write(REG_PAGE_SELECT, '{PWM_PAGE, UNLOCK_VALUE});
    check_val("page one", PWM_PAGE, page);
    reg_write(REG_PAGE_SELECT, '{BREATH_MODE_PAGE, UNLOCK_VALUE});
    check_val("page two", BREATH_MODE_PAGE, page);
    reg_write(REG_PAGE_SELECT, '{8'h07, UNLOCK_VALUE});
    check_val("reserved page", BREATH_MODE_PAGE, page);
    reg_write(REG_PAGE_SELECT, '{FUNCTION_PAGE, UNLOCK_VALUE});
    check_val("page three", FUNCTION_PAGE, page);
    seen_wr.delete();
    reg_write(8'h20, '{8'h11, 8'h22});
    check_val("paged writes", 24'h2, seen_wr.size());
    check_val("first write", 24'h032011, seen_wr[0]);
    check_val("second write", 24'h032122, seen_wr[1]);
    reg_write(REG_PAGE_SELECT, '{LED_CTRL_PAGE});
    reg_write(REG_PAGE_SELECT, '{PWM_PAGE});
    check_val("key used once", LED_CTRL_PAGE, page);
    $display("test page done");
    @(negedge sys_clk_in);
    f_wr = 1'b1;
    f_addr = 6'h02;
    f_data = 8'h5A;
    @(negedge sys_clk_in);
    f_wr = 1'b0;
    reg_read(8'h1A, rd);
    check_val("fault read", 24'h5A, rd);
    $display("test read done");
    reg_write(REG_IRQ_MASK, '{8'h01});
    pulse(5'h1E);
    check_bit("masked short", 1'b1, irq_n);
    pulse(5'h01);
    check_bit("open irq", 1'b0, irq_n);
    repeat (LIMIT * 2) @(negedge sys_clk_in);
    check_bit("no auto clear", 1'b0, irq_n);
    reg_read(REG_IRQ_FLAGS, rd);
    check_val("flags", 24'h1F, rd);
    check_bit("flags cleared", 1'b1, irq_n);
    reg_write(REG_IRQ_MASK, '{8'h0B});
    pulse(5'h02);
    check_bit("short irq", 1'b0, irq_n);
    repeat (LIMIT + 10) @(negedge sys_clk_in);
    check_bit("auto clear", 1'b1, irq_n);
    $display("test irq done");
    tally_and_finish();
  end
endmodule : testbench
bind led_matrix_i2c_host_port host_port_monitor #(.AUTO_CLEAR_LIMIT(AUTO_CLEAR_LIMIT)) u_mon (
  .sys_clk_in, .rst_in, .link_clk_in, .scl_in, .sda_out, .sda_oe_out, .irq_n_out, .page_out,
  .page_wr_en_out, .page_wr_page_out, .page_wr_addr_out, .page_wr_data_out);
